// ==== verilog/pes_pkg.sv ====
// Purpose: shared constants for the power event status register bank
// Assumes: byte-wide system I/O access at offsets inside a 24-byte block
// Notes: offsets, status flag bit positions, the status reset value and the override timing figures live here
package pes_pkg;
    // ==========================================================
    // register map
    localparam int PES_ADDR_W = 5;                            // 24-byte block
    localparam logic [4:0] PES_OFS_STATUS_TWO = 5'h01;        // power_event_status_two
    localparam logic [4:0] PES_OFS_ENABLE_ONE = 5'h02;        // power_event_enable_one
    localparam logic [7:0] PES_STATUS_RESET = 8'h00;
    localparam logic [7:0] PES_ENABLE_ONE_VALUE = 8'h00;      // every bit reserved
    // ==========================================================
    // status bit positions
    localparam int PES_BIT_BUTTON = 0;
    localparam int PES_BIT_ALARM = 2;
    localparam int PES_BIT_OVERRIDE = 3;
    localparam int PES_BIT_WAKE = 7;
    // ==========================================================
    // override hold timing, counted in slow real-time-clock ticks
    localparam int PES_OVR_HOLD_MS = 4000;                    // four seconds
    localparam int PES_RTC_HZ = 32768;
    localparam int PES_OVR_TICKS = PES_OVR_HOLD_MS * (PES_RTC_HZ / 1000) + 
        (PES_OVR_HOLD_MS * (PES_RTC_HZ % 1000)) / 1000;
    localparam int PES_CNT_W = 18;
    // ==========================================================
    // power state of the machine as seen by the power-on output
    typedef enum logic [0:0] {PES_OFF, PES_ON} pes_pwr_e;
endpackage

// ==== verilog/pes_sync.sv ====
// Purpose: two flip-flop synchroniser for asynchronous level inputs
// Assumes: inputs are slow levels compared with i_clk
// Notes: the first stage feeds only the second stage
`timescale 1ns/1ps
module pes_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // data
    input wire logic [WIDTH-1:0] i_d,
    output logic [WIDTH-1:0] o_q
);
    logic [WIDTH-1:0] meta_ff; // first stage, read only by o_q

    // ==========================================================
    // two-stage capture; no enable so a frozen block still sees fresh pins
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meta_ff <= '0;
            o_q <= '0;
        end else begin
            meta_ff <= i_d;
            o_q <= meta_ff;
        end
    end
endmodule // pes_sync

// ==== verilog/pes_regs.sv ====
// Purpose: power event status register two and enable register one
// Assumes: I/O strobes are one-cycle pulses on i_clk; enables come from
//          neighbouring control registers as same-clock levels
// Notes: the power-on output is open drain and active low
//
// Function
// - button press always sets button status
// - working state: button status and enable raise SCI
// - powered off: button press always wakes machine
// - hardware sets flags; write one clears
// - four-second hold: override flag, power off
// - alarm sets alarm flag; SCI when enabled
// - remembered alarm sets flag without standby power
// - power-on falling edge while sleeping sets wake
// - select set: enabled wake events set wake
// - wake clears only while power-on low
// - wake flag set moves system to working
// - reserved bits and enable one read zero
`timescale 1ns/1ps
module pes_regs
    import pes_pkg::*;
#(
    parameter int OVR_TICKS = PES_OVR_TICKS // shorten for simulation
) (
    // clock, reset, enable
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    // system I/O access
    input wire logic [PES_ADDR_W-1:0] i_io_addr,
    input wire logic i_io_rd,
    input wire logic i_io_wr,
    input wire logic [7:0] i_io_wdata,
    output logic [7:0] o_io_rdata,
    // pins and slow clock
    input wire logic i_button_in,
    input wire logic i_clk_32k,
    input wire logic i_rtc_alarm,
    input wire logic i_standby_ok,
    // enables and sleep controls from neighbouring registers
    input wire logic i_power_button_enable,
    input wire logic i_alarm_sci_enable,
    input wire logic i_alarm_memory_enable,
    input wire logic i_override_enable,
    input wire logic i_wake_source_select,
    input wire logic i_wake_event,
    input wire logic i_sleeping,
    input wire logic i_enter_soft_off,
    // outputs
    output logic o_sci,
    output logic o_resume,
    output logic o_power_on_request_n_o,
    output logic o_power_on_request_n_oe
);
    // ==========================================================
    // reset release and pin synchronisers
    logic [1:0] rst_sync_ff;  // reset release pipeline
    logic rst_n;              // released reset used everywhere
    logic [2:0] pin_s;        // synchronised button, slow clock, alarm
    logic btn_s;
    logic clk32_s;
    logic alarm_s;

    // reset asserts at once, releases two edges later
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    pes_sync #(.WIDTH(3)) u_sync (
        .i_clk(i_clk),
        .i_rst_b(rst_n),
        .i_d({i_rtc_alarm, i_clk_32k, i_button_in}),
        .o_q(pin_s)
    );
    assign btn_s = pin_s[0];
    assign clk32_s = pin_s[1];
    assign alarm_s = pin_s[2];

    // ==========================================================
    // state
    logic btn_d_ff;                // previous button level
    logic clk32_d_ff;              // previous slow clock level
    logic alarm_d_ff;              // previous alarm level
    logic [PES_CNT_W-1:0] hold_ff; // override hold count in slow ticks
    logic ovr_done_ff;             // override already fired for this hold
    logic [7:0] sts_ff;            // status register two
    pes_pwr_e pwr_ff;              // machine power state
    logic resume_ff;               // pulse: system sent to working
    logic [7:0] rdata_ff;          // read data holding register

    // ==========================================================
    // decode
    function automatic logic hit(input logic [PES_ADDR_W-1:0] a,
                                 input logic [PES_ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction

    logic wr_sts;       // write to status register two
    logic [7:0] clr_w1; // write-one-to-clear mask, reserved bits ignored
    logic btn_rise;     // button became asserted
    logic tick32;       // slow clock rising edge
    logic alarm_rise;   // alarm event
    logic sleeping;     // sleeping or soft-off
    logic ovr_fire;     // hold reached four seconds
    logic pon_fall;     // power-on output about to go low
    logic wake_set;     // wake flag set this cycle
    logic wake_clr_ok;  // wake flag clearable now
    logic alarm_set;    // alarm flag set this cycle
    logic [7:0] nxt_sts;
    pes_pwr_e nxt_pwr;
    logic [7:0] rd_mux;

    assign wr_sts = i_io_wr && hit(i_io_addr, PES_OFS_STATUS_TWO);
    // software is expected to write zeros into reserved positions
    assign clr_w1 = wr_sts ? (i_io_wdata & 8'h8D) : 8'h00;
    assign btn_rise = btn_s && !btn_d_ff;
    assign tick32 = clk32_s && !clk32_d_ff;
    assign alarm_rise = alarm_s && !alarm_d_ff;
    assign sleeping = (pwr_ff == PES_OFF) || i_sleeping;
    // one hardware firing per hold; ovr_done_ff blocks refiring while the count sits at the limit
    assign ovr_fire = i_override_enable && btn_s && !ovr_done_ff &&
        (hold_ff >= PES_CNT_W'(OVR_TICKS));
    // a press or enabled wake event turns the machine back on
    assign pon_fall = (pwr_ff == PES_OFF) && !ovr_fire &&
        (btn_rise || i_wake_event);
    assign wake_set = pon_fall ||
        (i_wake_source_select && sleeping && i_wake_event);
    assign wake_clr_ok = (pwr_ff == PES_ON);
    // without standby power the alarm only counts when remembered
    assign alarm_set = alarm_rise &&
        (i_standby_ok || i_alarm_memory_enable);

    // ==========================================================
    // next status: set beats clear in the same cycle
    always_comb begin
        nxt_sts = sts_ff & ~clr_w1;
        if (ovr_fire) begin
            nxt_sts[PES_BIT_BUTTON] = 1'b0;
            nxt_sts[PES_BIT_OVERRIDE] = 1'b1;
        end
        if (btn_rise) begin
            nxt_sts[PES_BIT_BUTTON] = 1'b1;
        end
        if (alarm_set) begin
            nxt_sts[PES_BIT_ALARM] = 1'b1;
        end
        if (!wake_clr_ok) begin
            nxt_sts[PES_BIT_WAKE] = sts_ff[PES_BIT_WAKE];
        end
        if (wake_set) begin
            nxt_sts[PES_BIT_WAKE] = 1'b1;
        end
        nxt_sts[6:4] = 3'h0;
        nxt_sts[1] = 1'b0;
    end

    // ==========================================================
    // power state machine: override and soft-off entry turn off, wake turns on
    always_comb begin
        case (pwr_ff)
            PES_ON: begin
                if (ovr_fire || i_enter_soft_off) begin
                    nxt_pwr = PES_OFF;
                end else begin
                    nxt_pwr = PES_ON;
                end
            end
            PES_OFF: begin
                nxt_pwr = wake_set ? PES_ON : PES_OFF;
            end
            default: begin
                nxt_pwr = PES_OFF;
            end
        endcase
        if (wake_set && !ovr_fire) begin
            nxt_pwr = PES_ON;
        end
    end

    // ==========================================================
    // read path; unmapped offsets read zero
    assign rd_mux = hit(i_io_addr, PES_OFS_STATUS_TWO) ? sts_ff :
        hit(i_io_addr, PES_OFS_ENABLE_ONE) ? PES_ENABLE_ONE_VALUE : 8'h00;

    // ==========================================================
    // edge history and override hold counter
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            btn_d_ff <= 1'b0;
            clk32_d_ff <= 1'b0;
            alarm_d_ff <= 1'b0;
            hold_ff <= '0;
            ovr_done_ff <= 1'b0;
        end else if (i_ce) begin
            btn_d_ff <= btn_s;
            clk32_d_ff <= clk32_s;
            alarm_d_ff <= alarm_s;
            // restart on release; saturate so a long hold cannot wrap
            if (!btn_s) begin
                hold_ff <= '0;
                ovr_done_ff <= 1'b0;
            end else begin
                if (tick32 && (hold_ff < PES_CNT_W'(OVR_TICKS))) begin
                    hold_ff <= hold_ff + 1'b1;
                end
                if (ovr_fire) begin
                    ovr_done_ff <= 1'b1;
                end
            end
        end
    end

    // status, power state, read data
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            sts_ff <= PES_STATUS_RESET;
            pwr_ff <= PES_OFF;
            resume_ff <= 1'b0;
            rdata_ff <= 8'h00;
        end else if (i_ce) begin
            sts_ff <= nxt_sts;
            pwr_ff <= nxt_pwr;
            resume_ff <= wake_set;
            if (i_io_rd) begin
                rdata_ff <= rd_mux;
            end
        end
    end

    // ==========================================================
    // outputs
    assign o_io_rdata = rdata_ff;
    assign o_resume = resume_ff;
    // SCI only in the working state; alarm SCI follows its own enable
    assign o_sci = !sleeping &&
        ((sts_ff[PES_BIT_BUTTON] && i_power_button_enable) ||
         (sts_ff[PES_BIT_ALARM] && i_alarm_sci_enable));
    // open drain: pull low while on, float while off
    assign o_power_on_request_n_o = 1'b0;
    assign o_power_on_request_n_oe = (pwr_ff == PES_ON);

    // ==========================================================
    // checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!rst_n);

    sequence s_wake_cause;
        i_ce && wake_set;
    endsequence
    sequence s_working;
        (pwr_ff == PES_ON) && resume_ff;
    endsequence

    button_set_a: assert property (i_ce && btn_rise |=> sts_ff[0])
        else $error("button press did not set button status");
    button_sci_a: assert property (!sleeping && sts_ff[0] && i_power_button_enable
        |-> o_sci)
        else $error("button status with enable gave no SCI");
    button_wake_a: assert property (i_ce && btn_rise && (pwr_ff == PES_OFF) && !ovr_fire
        |=> o_power_on_request_n_oe)
        else $error("button press did not wake machine");
    alarm_clear_a: assert property (i_ce && wr_sts && i_io_wdata[2] && !alarm_set
        |=> !sts_ff[2])
        else $error("write one did not clear alarm status");
    override_off_a: assert property (i_ce && ovr_fire && !btn_rise
        |=> sts_ff[3] && !sts_ff[0] && !o_power_on_request_n_oe)
        else $error("override hold did not power off");
    alarm_set_a: assert property (i_ce && alarm_rise && i_standby_ok |=> sts_ff[2])
        else $error("alarm did not set alarm status");
    alarm_memory_a: assert property (i_ce && alarm_rise && !i_standby_ok
        && !i_alarm_memory_enable && !sts_ff[2] && !clr_w1[2] |=> !sts_ff[2])
        else $error("forgotten alarm set alarm status");
    wake_edge_a: assert property (i_ce && pon_fall |=> sts_ff[7])
        else $error("power-on fall did not set wake status");
    wake_select_a: assert property (i_ce && i_wake_source_select && sleeping
        && i_wake_event |=> sts_ff[7])
        else $error("selected wake event did not set wake status");
    wake_keep_a: assert property (i_ce && sts_ff[7] && (pwr_ff == PES_OFF)
        |=> sts_ff[7])
        else $error("wake status cleared while powered off");
    wake_run_a: assert property ((s_wake_cause and !ovr_fire) |=> s_working)
        else $error("wake status did not move system to working");
    reserved_zero_a: assert property (i_ce && i_io_rd && !hit(i_io_addr, PES_OFS_STATUS_TWO)
        |=> o_io_rdata == 8'h00)
        else $error("reserved or unmapped read not zero");
    hold_restart_a: assert property (i_ce && !btn_s |=> hold_ff == '0)
        else $error("override count did not restart on release");
endmodule // pes_regs

// ==== test/pes_pin_model.sv ====
// Purpose: model of the power button, alarm line and slow clock
// Assumes: driven from the bench through tasks, changes at i_clk rise
// Notes: slow clock runs free, sped up to keep the run short
`timescale 1ns/1ps
module pes_pin_model #(
    parameter int SLOW_HALF_NS = 2000 // faster than 32 kHz on purpose
) (
    // clock
    input wire logic i_clk,
    // pins
    output logic o_button,
    output logic o_alarm,
    output logic o_clk_32k
);
    // =======================================================
    // slow clock, free running like the real oscillator
    initial begin
        o_button = 1'b0;
        o_alarm = 1'b0;
        o_clk_32k = 1'b0;
        forever #(SLOW_HALF_NS) o_clk_32k = ~o_clk_32k;
    end
    // hold the button for n cycles, then release
    task automatic press(input int n);
        @(posedge i_clk) o_button <= 1'b1;
        repeat (n) @(posedge i_clk);
        o_button <= 1'b0;
    endtask
    // one alarm event as a short high level
    task automatic alarm();
        @(posedge i_clk) o_alarm <= 1'b1;
        repeat (4) @(posedge i_clk);
        o_alarm <= 1'b0;
    endtask
endmodule // pes_pin_model

// ==== test/pes_regs_tb.sv ====
// Purpose: self-checking bench for the power event status bank
// Assumes: override hold shortened to 4 slow ticks
// Notes: host accesses are one-cycle strobes at offsets 0x01/0x02, plus one read at 0x05
`timescale 1ns/1ps
module pes_regs_tb;
    import pes_pkg::*;
    // =======================================================
    // stimulus and observation signals
    logic i_clk, i_rst_b;
    logic [PES_ADDR_W-1:0] i_io_addr;
    logic i_io_rd, i_io_wr;
    logic [7:0] i_io_wdata, o_io_rdata;
    logic btn, alm, slow;
    logic i_standby_ok, i_power_button_enable, i_alarm_sci_enable;
    logic i_alarm_memory_enable, i_override_enable, i_wake_source_select;
    logic i_wake_event, i_sleeping, i_enter_soft_off, i_ce;
    logic o_sci, o_resume, pon_o, pon_oe;
    int n_errors = 0;
    int samples_checked = 0;
    int n_resume = 0;
    // =======================================================
    // design and far side
    pes_regs #(.OVR_TICKS(4)) uut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(i_ce),
        .i_io_addr(i_io_addr), .i_io_rd(i_io_rd), .i_io_wr(i_io_wr),
        .i_io_wdata(i_io_wdata), .o_io_rdata(o_io_rdata), .i_button_in(btn),
        .i_clk_32k(slow), .i_rtc_alarm(alm), .i_standby_ok(i_standby_ok),
        .i_power_button_enable(i_power_button_enable),
        .i_alarm_sci_enable(i_alarm_sci_enable),
        .i_alarm_memory_enable(i_alarm_memory_enable),
        .i_override_enable(i_override_enable),
        .i_wake_source_select(i_wake_source_select), .i_wake_event(i_wake_event),
        .i_sleeping(i_sleeping), .i_enter_soft_off(i_enter_soft_off), .o_sci(o_sci),
        .o_resume(o_resume), .o_power_on_request_n_o(pon_o),
        .o_power_on_request_n_oe(pon_oe));
    pes_pin_model pins (.i_clk(i_clk), .o_button(btn), .o_alarm(alm), .o_clk_32k(slow));
    // =======================================================
    // clock, resume pulse counter
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        if (o_resume === 1'b1) n_resume++;
    end
    // compare one value, report at once on a mismatch
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // read one byte and compare
    task automatic rd(input logic [4:0] a, input logic [7:0] exp);
        @(posedge i_clk) i_io_addr <= a;
        i_io_rd <= 1'b1;
        @(posedge i_clk) i_io_rd <= 1'b0;
        @(posedge i_clk) #1 chk(o_io_rdata, exp);
    endtask
    // write one byte, reserved bits always zero
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge i_clk) i_io_addr <= a;
        i_io_wr <= 1'b1;
        i_io_wdata <= d;
        @(posedge i_clk) i_io_wr <= 1'b0;
        @(posedge i_clk);
    endtask
    // one-cycle pulse on a wake event, then four idle cycles
    task automatic wake_pulse();
        @(posedge i_clk) i_wake_event <= 1'b1;
        @(posedge i_clk) i_wake_event <= 1'b0;
        repeat (4) @(posedge i_clk);
    endtask
    // verdict, the only place the run ends
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // watchdog, far beyond the expected run of about 700 cycles
    initial begin
        #3000000;
        n_errors++;
        final_report();
    end
    // =======================================================
    // test sequence
    initial begin
        {i_io_addr, i_io_rd, i_io_wr, i_io_wdata} = '0;
        {i_power_button_enable, i_alarm_sci_enable, i_alarm_memory_enable} = '0;
        {i_override_enable, i_wake_source_select, i_wake_event} = '0;
        {i_sleeping, i_enter_soft_off} = '0;
        i_standby_ok = 1'b1;
        i_ce = 1'b1;
        i_rst_b = 1'b0;
        repeat (3) @(posedge i_clk);
        i_rst_b <= 1'b1;
        repeat (4) @(posedge i_clk);
        rd(5'h01, 8'h00);
        rd(5'h02, 8'h00);
        rd(5'h05, 8'h00);
        chk({6'h00, pon_o, pon_oe}, 8'h00);
        $display("reset test done");
        pins.press(10); // press while off, enable clear
        repeat (6) @(posedge i_clk);
        rd(5'h01, 8'h81);
        chk({6'h00, pon_o, pon_oe}, 8'h01);
        chk(n_resume[7:0], 8'h01);
        chk({7'h00, o_sci}, 8'h00);
        @(posedge i_clk) i_power_button_enable <= 1'b1;
        @(posedge i_clk) #1 chk({7'h00, o_sci}, 8'h01);
        i_sleeping <= 1'b1;
        @(posedge i_clk) #1 chk({7'h00, o_sci}, 8'h00);
        i_sleeping <= 1'b0;
        i_power_button_enable <= 1'b0;
        wr(5'h01, 8'h00);
        rd(5'h01, 8'h81);
        wr(5'h01, 8'h01);
        rd(5'h01, 8'h80);
        wr(5'h01, 8'h80);
        rd(5'h01, 8'h00);
        $display("button test done");
        i_alarm_sci_enable <= 1'b1;
        pins.alarm();
        repeat (5) @(posedge i_clk);
        rd(5'h01, 8'h04);
        chk({7'h00, o_sci}, 8'h01);
        // a write while the block is frozen must not clear anything
        i_ce <= 1'b0;
        wr(5'h01, 8'h04);
        i_ce <= 1'b1;
        rd(5'h01, 8'h04);
        wr(5'h01, 8'h04);
        i_standby_ok <= 1'b0;
        i_alarm_memory_enable <= 1'b1;
        pins.alarm();
        repeat (5) @(posedge i_clk);
        rd(5'h01, 8'h04);
        wr(5'h01, 8'h04);
        i_alarm_memory_enable <= 1'b0;
        pins.alarm();
        repeat (5) @(posedge i_clk);
        rd(5'h01, 8'h00);
        i_standby_ok <= 1'b1;
        i_alarm_sci_enable <= 1'b0;
        $display("alarm test done");
        i_override_enable <= 1'b1;
        pins.press(100); // two short holds, count must restart
        repeat (5) @(posedge i_clk);
        pins.press(100);
        repeat (6) @(posedge i_clk);
        rd(5'h01, 8'h01);
        wr(5'h01, 8'h01);
        pins.press(300);
        repeat (6) @(posedge i_clk);
        rd(5'h01, 8'h08);
        chk({7'h00, pon_oe}, 8'h00);
        i_override_enable <= 1'b0;
        wr(5'h01, 8'h08);
        $display("override test done");
        wake_pulse();
        rd(5'h01, 8'h80);
        @(posedge i_clk) i_enter_soft_off <= 1'b1;
        @(posedge i_clk) i_enter_soft_off <= 1'b0;
        repeat (4) @(posedge i_clk);
        wr(5'h01, 8'h80);
        rd(5'h01, 8'h80);
        wake_pulse();
        wr(5'h01, 8'h80);
        rd(5'h01, 8'h00);
        i_sleeping <= 1'b1;
        i_wake_source_select <= 1'b1;
        wake_pulse();
        rd(5'h01, 8'h80);
        wr(5'h01, 8'h80);
        i_wake_source_select <= 1'b0;
        wake_pulse();
        rd(5'h01, 8'h00);
        i_sleeping <= 1'b0;
        chk(n_resume[7:0], 8'h04);
        $display("wake test done");
        final_report();
    end
endmodule // pes_regs_tb
